// ### pkg/slrb_pkg.sv
// package for the serial load register bank: widths, address codes, presets
// assumes nothing of its surroundings; shared by the core and the shifter
package slrb_pkg;
   localparam int unsigned WORD_W = 32;
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = WORD_W - ADDR_W;
   localparam int unsigned BANK_N = 4;

   // address codes carried in the low three bits of each word
   localparam logic [ADDR_W-1:0] ADDR_PRESET  = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_IF_REF  = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_IF_FB   = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_RF_REF  = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_RF_FB   = 3'h4;

   // bank indices
   localparam int unsigned BANK_IF_REF = 0;
   localparam int unsigned BANK_IF_FB  = 1;
   localparam int unsigned BANK_RF_REF = 2;
   localparam int unsigned BANK_RF_FB  = 3;

   // don't-care masks per bank (1 = meaningful bit of the 29-bit data field)
   // word bit 3 (data bit 0) is don't care in both intermediate words
   localparam logic [DATA_W-1:0] MASK_IF_REF = 29'h1FFF_FFFE;
   localparam logic [DATA_W-1:0] MASK_IF_FB  = 29'h1FFF_FFFE;
   localparam logic [DATA_W-1:0] MASK_RF_REF = 29'h1FFF_FFFF;
   localparam logic [DATA_W-1:0] MASK_RF_FB  = 29'h1FFF_FFFF;

   // preset contents loaded on address 000 (plain defaults)
   localparam logic [DATA_W-1:0] PRESET_IF_REF = 29'h0000_0000;
   localparam logic [DATA_W-1:0] PRESET_IF_FB  = 29'h0000_0000;
   localparam logic [DATA_W-1:0] PRESET_RF_REF = 29'h0000_0000;
   localparam logic [DATA_W-1:0] PRESET_RF_FB  = 29'h0000_0000;

   localparam logic [WORD_W-1:0] SHIFT_RESET = 32'h0000_0000;
   localparam logic [1:0]        SYNC_RESET  = 2'h0;
endpackage

// ### rtl/slrb_shifter.sv
// serial shifter on the link clock: 32-bit shift register, msb first
// assumes sclk runs only while the strobe is low and data is stable at rise
`timescale 1ns/10ps
`default_nettype none
module slrb_shifter (
   input  wire logic                       sclk_in,
   input  wire logic                       arst_n_in,
   input  wire logic                       sdata_in,
   output logic [slrb_pkg::WORD_W-1:0]     shift_out
);
   import slrb_pkg::*;

   logic [WORD_W-1:0] shift_r;
   logic [WORD_W-1:0] shift_nxt;

   // -----------------------------
   // shift path
   // -----------------------------
   // new bit enters at bit 0, so the first bit ends at bit 31
   assign shift_nxt = {shift_r[WORD_W-2:0], sdata_in};  // [R2] [R3]

   always_ff @(posedge sclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         shift_r <= SHIFT_RESET;
      end else begin
         shift_r <= shift_nxt;  // [R2]
      end
   end

   assign shift_out = shift_r;
endmodule
`default_nettype wire

// ### rtl/slrb_core.sv
// serial load register bank: three-wire port loading four control banks
// assumes sclk_in comes from the host; strobe sampled in the clk_in domain
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R1: only serial clock, data and load strobe are used, all inputs to the device.
// R2: data is sampled on each rising serial clock into a 32-bit shift register.
// R3: the host sends bit 31 first and bit 0 last.
// R4: the last three bits shifted (bits 2..0) are the bank address.
// R5: a rising load strobe copies the data field into the addressed bank.
// R6: don't-care bit positions never affect a latched setting.
// R7: the host holds the strobe low while shifting bits.
// R8: address 000 loads every bank with its preset contents.
// R9: after a preset, later words to other addresses still load normally.
// R10: the port keeps working whatever the power state of the synthesizers.
// R11: 001/010/011/100 select the four banks; other codes are ignored.
module slrb_core (
   input  wire logic                       clk_in,
   input  wire logic                       arst_n_in,
   input  wire logic                       sclk_in,
   input  wire logic                       sdata_in,
   input  wire logic                       load_strobe_in,
   output logic [slrb_pkg::DATA_W-1:0]     intermediate_ref_divider_word_out,
   output logic [slrb_pkg::DATA_W-1:0]     intermediate_feedback_divider_word_out,
   output logic [slrb_pkg::DATA_W-1:0]     radio_ref_divider_word_out,
   output logic [slrb_pkg::DATA_W-1:0]     radio_feedback_divider_word_out,
   output logic                            load_pulse_out
);
   import slrb_pkg::*;

   // -----------------------------
   // reset synchroniser
   // -----------------------------
   logic [1:0] rst_sync_r;
   logic       rst_n_w;

   // assert at once, release two clk_in edges after the pin so that no
   // clk_in flop sees the end of reset close to its edge; the shifter keeps
   // the raw pin, as its clock stands still whenever reset is released
   // trade-off: two cycles of extra reset latency for a clean release
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_sync_r <= SYNC_RESET;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   assign rst_n_w = rst_sync_r[1];  // only the second flop is read

   // -----------------------------
   // timing overview
   // -----------------------------
   // the word is shifted on sclk_in and read here only once the strobe has
   // passed the two-flop synchroniser below; the host keeps sclk_in still
   // while the strobe is high, so the word is quiet when it is sampled
   // strobe rise to bank update takes three to four clk_in edges, and a
   // strobe pulse shorter than one clk_in period may be missed
   // more than 32 rises between strobes is harmless: only the last 32 bits
   // remain in the shift register when the strobe rises
   // banks and the load pulse hold their reset values until the second
   // clk_in edge after the reset pin is released
   // limitation: clocking sclk_in while the strobe is high corrupts the
   // word seen at the load edge; a capture register would cost 32 flops

   // -----------------------------
   // link domain shifter
   // -----------------------------
   logic [WORD_W-1:0] shift_w;

   // three pins only, all inputs [R1]
   slrb_shifter u_shift (
      .sclk_in   (sclk_in),
      .arst_n_in (arst_n_in),
      .sdata_in  (sdata_in),
      .shift_out (shift_w)
   );

   // -----------------------------
   // strobe synchroniser and edge
   // -----------------------------
   logic [1:0] le_sync_r;
   logic       le_prev_r;
   logic       le_rise;

   // the shift word is stable while the strobe is high (no sclk), so the
   // word itself can be sampled once the synchronised strobe has risen [R7]
   always_ff @(posedge clk_in or negedge rst_n_w) begin
      if (!rst_n_w) begin
         le_sync_r <= SYNC_RESET;
         le_prev_r <= 1'b0;
      end else begin
         le_sync_r <= {le_sync_r[0], load_strobe_in};
         le_prev_r <= le_sync_r[1];
      end
   end

   assign le_rise = le_sync_r[1] & ~le_prev_r;  // [R5]

   // -----------------------------
   // address decode
   // -----------------------------
   logic [ADDR_W-1:0] addr_w;
   logic [DATA_W-1:0] data_w;
   logic              hit_preset;
   logic [BANK_N-1:0] hit_bank;

   // shared compare: a code counts only in the cycle of the strobe edge
   // kept as a function so that every bank and the preset use one compare
   function automatic logic addr_hit(
      input logic              strobe_edge,
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] code
   );
      return strobe_edge & (addr == code);
   endfunction

   // word layout: data field above, address in the low bits
   assign addr_w     = shift_w[ADDR_W-1:0];        // [R4]
   assign data_w     = shift_w[WORD_W-1:ADDR_W];
   assign hit_preset = addr_hit(le_rise, addr_w, ADDR_PRESET);  // [R8]
   // unknown codes 101..111 match no bank and are dropped [R11]
   assign hit_bank[BANK_IF_REF] = addr_hit(le_rise, addr_w, ADDR_IF_REF);  // [R11]
   assign hit_bank[BANK_IF_FB]  = addr_hit(le_rise, addr_w, ADDR_IF_FB);
   assign hit_bank[BANK_RF_REF] = addr_hit(le_rise, addr_w, ADDR_RF_REF);
   assign hit_bank[BANK_RF_FB]  = addr_hit(le_rise, addr_w, ADDR_RF_FB);

   // -----------------------------
   // bank registers
   // -----------------------------
   // masked write: don't-care bits are forced to zero
   function automatic logic [DATA_W-1:0] bank_next(
      input logic              preset,
      input logic              hit,
      input logic [DATA_W-1:0] cur,
      input logic [DATA_W-1:0] din,
      input logic [DATA_W-1:0] mask,
      input logic [DATA_W-1:0] pre
   );
      logic [DATA_W-1:0] res;
      res = cur;
      if (preset) begin
         res = pre;  // [R8]
      end else if (hit) begin
         res = din & mask;  // [R6] [R9]
      end
      return res;
   endfunction

   logic [DATA_W-1:0] if_ref_r, if_ref_nxt;
   logic [DATA_W-1:0] if_fb_r,  if_fb_nxt;
   logic [DATA_W-1:0] rf_ref_r, rf_ref_nxt;
   logic [DATA_W-1:0] rf_fb_r,  rf_fb_nxt;
   logic              load_r;

   assign if_ref_nxt = bank_next(hit_preset, hit_bank[BANK_IF_REF], if_ref_r, data_w,
                                 MASK_IF_REF, PRESET_IF_REF);
   assign if_fb_nxt  = bank_next(hit_preset, hit_bank[BANK_IF_FB], if_fb_r, data_w,
                                 MASK_IF_FB, PRESET_IF_FB);
   assign rf_ref_nxt = bank_next(hit_preset, hit_bank[BANK_RF_REF], rf_ref_r, data_w,
                                 MASK_RF_REF, PRESET_RF_REF);
   assign rf_fb_nxt  = bank_next(hit_preset, hit_bank[BANK_RF_FB], rf_fb_r, data_w,
                                 MASK_RF_FB, PRESET_RF_FB);

   // banks come up at their preset contents, the same as an address 000 load;
   // no power-down input gates these paths: banks load in every power state [R10]
   // intermediate reference bank, address 001
   always_ff @(posedge clk_in or negedge rst_n_w) begin
      if (!rst_n_w) begin
         if_ref_r <= PRESET_IF_REF;
      end else begin
         if_ref_r <= if_ref_nxt;  // [R5]
      end
   end

   // intermediate feedback bank, address 010
   always_ff @(posedge clk_in or negedge rst_n_w) begin
      if (!rst_n_w) begin
         if_fb_r <= PRESET_IF_FB;
      end else begin
         if_fb_r <= if_fb_nxt;  // [R5]
      end
   end

   // radio reference bank, address 011
   always_ff @(posedge clk_in or negedge rst_n_w) begin
      if (!rst_n_w) begin
         rf_ref_r <= PRESET_RF_REF;
      end else begin
         rf_ref_r <= rf_ref_nxt;  // [R5]
      end
   end

   // radio feedback bank, address 100
   always_ff @(posedge clk_in or negedge rst_n_w) begin
      if (!rst_n_w) begin
         rf_fb_r <= PRESET_RF_FB;
      end else begin
         rf_fb_r <= rf_fb_nxt;  // [R5]
      end
   end

   // one clk_in cycle per strobe rise, whatever code the word carried;
   // unknown codes still pulse, so a watcher can see that the strobe arrived
   always_ff @(posedge clk_in or negedge rst_n_w) begin
      if (!rst_n_w) begin
         load_r <= 1'b0;
      end else begin
         load_r <= le_rise;
      end
   end

   // -----------------------------
   // outputs
   // -----------------------------
   // data outputs come straight from the bank flops; nothing is decoded
   // after them, so the settings never glitch at a load
   assign intermediate_ref_divider_word_out      = if_ref_r;
   assign intermediate_feedback_divider_word_out = if_fb_r;
   assign radio_ref_divider_word_out             = rf_ref_r;
   assign radio_feedback_divider_word_out        = rf_fb_r;
   assign load_pulse_out                         = load_r;  // one cycle per strobe rise
endmodule
`default_nettype wire

// ### dv/slrb_host.sv
// host model: drives clock, data and strobe of the three-wire port
// assumes the bench calls send(); sclk stands still between words
`timescale 1ns/10ps
`default_nettype none
module slrb_host (
   output logic sclk_out,
   output logic sdata_out,
   output logic strobe_out
);
   initial begin
      sclk_out = 1'b0;
      sdata_out = 1'b0;
      strobe_out = 1'b0;
   end
   // strobe low first, 32 rises msb first, then strobe high
   task automatic send(input logic [31:0] w);
      strobe_out = 1'b0;
      #100;
      for (int i = 31; i >= 0; i--) begin
         sdata_out = w[i];
         #62.5 sclk_out = 1'b1;
         #62.5 sclk_out = 1'b0;
      end
      sdata_out = ~w[0]; // line driven to the inverse of bit 0: no stale bit
      #100 strobe_out = 1'b1;
      #400; // strobe held well past the sync latency
   endtask
endmodule
`default_nettype wire

// ### dv/slrb_core_sva.sv
// checker for slrb_core: pulse timing, bank selection, preset, mask
// assumes bind into slrb_core; mirrors the shift register on sclk_in
`timescale 1ns/10ps
`default_nettype none
module slrb_core_sva import slrb_pkg::*; (
   input wire logic                        clk_in,
   input wire logic                        arst_n_in,
   input wire logic                        sclk_in,
   input wire logic                        sdata_in,
   input wire logic                        load_strobe_in,
   input wire logic [slrb_pkg::DATA_W-1:0] intermediate_ref_divider_word_out,
   input wire logic [slrb_pkg::DATA_W-1:0] intermediate_feedback_divider_word_out,
   input wire logic [slrb_pkg::DATA_W-1:0] radio_ref_divider_word_out,
   input wire logic [slrb_pkg::DATA_W-1:0] radio_feedback_divider_word_out,
   input wire logic                        load_pulse_out
);
   logic [WORD_W-1:0] sh;
   wire logic [DATA_W-1:0] b1 = intermediate_ref_divider_word_out;
   wire logic [DATA_W-1:0] b2 = intermediate_feedback_divider_word_out;
   wire logic [DATA_W-1:0] b3 = radio_ref_divider_word_out;
   wire logic [DATA_W-1:0] b4 = radio_feedback_divider_word_out;
   // own copy of the word; valid while sclk stands still at a load
   always_ff @(posedge sclk_in or negedge arst_n_in) begin
      if (!arst_n_in) sh <= '0;
      else sh <= {sh[WORD_W-2:0], sdata_in};
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   sequence s_rise; $rose(load_strobe_in); endsequence
   sequence s_load(logic [2:0] c); load_pulse_out && sh[2:0] == c; endsequence
   property p_lat; s_rise |-> ##[2:4] load_pulse_out; endproperty
   a_lat: assert property (p_lat) else $error("load pulse late");
   property p_once; load_pulse_out |=> !load_pulse_out; endproperty
   a_once: assert property (p_once) else $error("pulse too long");
   property p_hold; $changed({b1, b2, b3, b4}) |-> load_pulse_out; endproperty
   a_hold: assert property (p_hold) else $error("bank moved alone");
   property p_mask; b1[0] == 1'b0 && b2[0] == 1'b0; endproperty
   a_mask: assert property (p_mask) else $error("don't care kept");
   property p_pre; s_load(ADDR_PRESET) |-> {b1, b2, b3, b4} ==
      {PRESET_IF_REF, PRESET_IF_FB, PRESET_RF_REF, PRESET_RF_FB}; endproperty
   a_pre: assert property (p_pre) else $error("preset wrong");
   property p_ifr; s_load(ADDR_IF_REF) |-> b1 == (sh[31:3] & MASK_IF_REF); endproperty
   a_ifr: assert property (p_ifr) else $error("if ref wrong");
   property p_iff; s_load(ADDR_IF_FB) |-> b2 == (sh[31:3] & MASK_IF_FB); endproperty
   a_iff: assert property (p_iff) else $error("if fb wrong");
   property p_rfr; s_load(ADDR_RF_REF) |-> b3 == sh[31:3]; endproperty
   a_rfr: assert property (p_rfr) else $error("rf ref wrong");
   property p_rff; s_load(ADDR_RF_FB) |-> b4 == sh[31:3]; endproperty
   a_rff: assert property (p_rff) else $error("rf fb wrong");
   property p_skip; load_pulse_out && sh[2:0] > 3'h4 |-> $stable({b1, b2, b3, b4}); endproperty
   a_skip: assert property (p_skip) else $error("bad code loaded");
endmodule
bind slrb_core slrb_core_sva u_sva (
   .clk_in                                 (clk_in),
   .arst_n_in                              (arst_n_in),
   .sclk_in                                (sclk_in),
   .sdata_in                               (sdata_in),
   .load_strobe_in                         (load_strobe_in),
   .intermediate_ref_divider_word_out      (intermediate_ref_divider_word_out),
   .intermediate_feedback_divider_word_out (intermediate_feedback_divider_word_out),
   .radio_ref_divider_word_out             (radio_ref_divider_word_out),
   .radio_feedback_divider_word_out        (radio_feedback_divider_word_out),
   .load_pulse_out                         (load_pulse_out)
);
`default_nettype wire

// ### dv/tb_slrb_core.sv
// bench for slrb_core: every bank, unused codes, preset then reload
// assumes slrb_host as far side; only mismatches and verdict print
`timescale 1ns/10ps
`default_nettype none
module tb_slrb_core;
   import slrb_pkg::*;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   wire logic sclk, sdata, strobe;
   wire logic load_pulse;
   int n_pulses = 0;
   logic [DATA_W-1:0] b [1:4];
   logic [DATA_W-1:0] e [1:4];
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   always #25 clk_in = ~clk_in;
   slrb_host host (.sclk_out(sclk), .sdata_out(sdata), .strobe_out(strobe));
   slrb_core uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .sclk_in(sclk),
      .sdata_in(sdata), .load_strobe_in(strobe), .load_pulse_out(load_pulse),
      .intermediate_ref_divider_word_out(b[1]), .radio_ref_divider_word_out(b[3]),
      .intermediate_feedback_divider_word_out(b[2]), .radio_feedback_divider_word_out(b[4]));
   task automatic end_of_test();
      if (n_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // pulses counted mid-cycle, away from the edge that launches them
   always @(negedge clk_in) if (load_pulse === 1'b1) n_pulses++;
   task automatic check(input string what, input logic [DATA_W-1:0] s,
                        input logic [DATA_W-1:0] x);
      comparisons++;
      if (s !== x) begin
         n_errors++;
         $display("ERROR %s exp %h seen %h", what, x, s);
      end
   endtask
   task automatic cmp_all();
      for (int k = 1; k < 5; k++) begin
         check($sformatf("bank%0d", k), b[k], e[k]);
      end
   endtask
   // one word through the host, expectation kept alongside
   task automatic load(input logic [2:0] a, input logic [DATA_W-1:0] d);
      int p;
      p = n_pulses;
      @(posedge clk_in) #2 host.send({d, a});
      if (a == ADDR_PRESET) e = '{PRESET_IF_REF, PRESET_IF_FB, PRESET_RF_REF, PRESET_RF_FB};
      else if (a == ADDR_IF_REF) e[a] = d & MASK_IF_REF;
      else if (a == ADDR_IF_FB) e[a] = d & MASK_IF_FB;
      else if (a == ADDR_RF_REF) e[a] = d & MASK_RF_REF;
      else if (a == ADDR_RF_FB) e[a] = d & MASK_RF_FB;
      cmp_all();
      check("load_pulses", DATA_W'(n_pulses - p), DATA_W'(1));
   endtask
   task automatic t_reset();
      e = '{PRESET_IF_REF, PRESET_IF_FB, PRESET_RF_REF, PRESET_RF_FB};
      cmp_all();
   endtask
   // back to back; the don't-care bit and its neighbour are set in every word
   task automatic t_banks();
      for (int a = 1; a < 5; a++) load(a[2:0], 29'(29'h1ABC_DE0F ^ (a << 8)));
   endtask
   task automatic t_ignored();
      for (int a = 5; a < 8; a++) load(a[2:0], 29'h0F0F_0F0F);
   endtask
   task automatic t_preset();
      load(ADDR_PRESET, 29'h1FFF_FFFF);
      load(ADDR_RF_FB, 29'h0123_4567);
   endtask
   initial begin
      repeat (10) @(posedge clk_in);
      #2 arst_n_in = 1'b1;
      t_reset();
      t_banks();
      t_ignored();
      t_preset();
      end_of_test();
   end
   // nine words take about 840 cycles; the ceiling leaves margin
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         end_of_test();
      end
   end
endmodule
`default_nettype wire
